//--- wdt_top.sv
// Two-stage watchdog timer control, lock and time-out logic
`timescale 1ns/1ns
`include "wdt_defs.svh"
// Functional notes
// - Counter counts down; zero is first time-out
// - After first time-out reload and keep counting
// - Second zero with pending interrupt asserts reset
// - Cleared interrupt: reload, resume, no reset
// - Load write reloads counter immediately
// - Only clear write removes pending interrupt
// - Enabling interrupt preloads counter from load
// - Interrupt enable starts counter, locks control
// - Any lock write locks; key unlocks
// - Zero load value raises interrupt immediately
// - Clear write clears interrupt and reloads
// - Control bit1 reset enable, bit0 interrupt
// - Masked status is raw AND enable
module wdt_top (
    input  wire logic              clk_in,
    input  wire logic              resetn_in,
    input  wire logic              load_wr_in,
    input  wire wdt_pkg::wdt_word_t load_data_in,
    input  wire logic              ctrl_wr_in,
    input  wire logic [1:0]        ctrl_data_in,
    input  wire logic              irq_clear_wr_in,
    input  wire logic              guard_wr_in,
    input  wire wdt_pkg::wdt_word_t guard_data_in,
    input  wire logic              stall_enable_in,
    input  wire logic              debug_halt_in,
    output wdt_pkg::wdt_word_t     reload_value_out,
    output wdt_pkg::wdt_word_t     count_value_out,
    output logic [1:0]             ctrl_out,
    output logic                   raw_irq_out,
    output logic                   masked_irq_out,
    output logic                   guard_locked_out,
    output logic                   timeout_irq_signal_out,
    output logic                   system_reset_out
);
    import wdt_pkg::*;

    // The counter only loads, counts and flags zero; this module owns the
    // write locks, the interrupt flag and the reset stage. The reset output
    // is a level that only resetn_in removes, so a stuck system stays held.

    // Configuration, flag and sequencing state
    wdt_word_t  reload_value_reg;
    logic       reset_output_enable;
    logic       timeout_irq_enable;
    logic       raw_irq;
    logic       locked;
    logic       sys_reset;
    wdt_state_e state;
    wdt_state_e next_state;

    // Synchroniser stages for the debug lines
    logic       halt_q1;
    logic       halt_q2;
    logic       stall_q1;
    logic       stall_q2;

    // Qualified write strobes and time-out events
    logic       load_ok;
    logic       ctrl_ok;
    logic       enable_rise;
    logic       zero_load_evt;
    logic       first_timeout;
    logic       second_timeout;

    wdt_cnt_if cif ();

    wdt_counter u_counter (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .cnt       (cif.cnt)
    );

    // Debug halt comes from outside the domain; two stages before any use
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            halt_q1 <= 1'b0;
            halt_q2 <= 1'b0;
        end else begin
            halt_q1 <= debug_halt_in;
            halt_q2 <= halt_q1;
        end
    end

    // Stall option is a pin level as well, synchronised the same way
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            stall_q1 <= 1'b0;
            stall_q2 <= 1'b0;
        end else begin
            stall_q1 <= stall_enable_in;
            stall_q2 <= stall_q1;
        end
    end

    // Write qualification by the guard and the control lock
    assign load_ok       = load_wr_in && !locked;
    assign ctrl_ok       = ctrl_wr_in && !locked && !timeout_irq_enable;
    assign enable_rise   = ctrl_ok && ctrl_data_in[`WDT_CTL_TIMEOUT_IRQ_ENABLE];
    assign zero_load_evt = load_ok && (load_data_in == 32'h00000000);

    // Time-out events; a clear in the zero cycle spares the system reset
    assign first_timeout  = cif.zero;
    assign second_timeout = cif.zero && raw_irq && !irq_clear_wr_in && reset_output_enable;

    // Guard register: any write locks, the key unlocks
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            locked <= 1'b0;
        end else if (guard_wr_in) begin
            locked <= (guard_data_in != `WDT_UNLOCK_KEY);
        end
    end

    // Load value register
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            reload_value_reg <= `WDT_LOAD_RESET;
        end else if (load_ok) begin
            reload_value_reg <= load_data_in;
        end
    end

    // Reset output enable; writable only until the interrupt is enabled
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            reset_output_enable <= 1'b0;
        end else if (ctrl_ok) begin
            reset_output_enable <= ctrl_data_in[`WDT_CTL_RESET_OUTPUT_ENABLE];
        end
    end

    // Interrupt enable is sticky: ctrl_ok is refused once it is set
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            timeout_irq_enable <= 1'b0;
        end else if (ctrl_ok) begin
            timeout_irq_enable <= ctrl_data_in[`WDT_CTL_TIMEOUT_IRQ_ENABLE];
        end
    end

    // Counter steering: every reload source uses the freshest load value
    always_comb begin
        cif.load       = load_ok || enable_rise || irq_clear_wr_in || cif.zero;
        cif.load_value = load_ok ? load_data_in : reload_value_reg;
        cif.run        = timeout_irq_enable && !sys_reset && !(stall_q2 && halt_q2);
        if (load_ok) begin
            cif.load_value = load_data_in;
        end else if (enable_rise) begin
            cif.load_value = reload_value_reg;
        end else if (irq_clear_wr_in) begin
            cif.load_value = reload_value_reg;
        end else begin
            cif.load_value = reload_value_reg;
        end
    end

    // Next sequencing state; the reset stage is final until hardware reset
    always_comb begin
        next_state = state;
        case (state)
            WDT_IDLE: begin
                if (enable_rise) begin
                    next_state = WDT_RUN;
                end
            end
            WDT_RUN: begin
                if (second_timeout) begin
                    next_state = WDT_FIRED;
                end
            end
            WDT_FIRED: begin
                next_state = WDT_FIRED;
            end
            default: begin
                next_state = WDT_IDLE;
            end
        endcase
    end

    // Sequencing state register
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            state <= WDT_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Raw interrupt flag; a time-out in the clear cycle keeps the flag set
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            raw_irq <= 1'b0;
        end else if (first_timeout || zero_load_evt) begin
            raw_irq <= 1'b1;
        end else if (irq_clear_wr_in) begin
            raw_irq <= 1'b0;
        end
    end

    // System reset holds until hardware reset removes it
    assign sys_reset = (state == WDT_FIRED);

    // Register views
    always_comb begin
        reload_value_out = reload_value_reg;
        count_value_out  = cif.value;
        ctrl_out         = {reset_output_enable, timeout_irq_enable};
        guard_locked_out = locked;
    end

    // Interrupt and reset views; the interrupt line is the masked status
    always_comb begin
        raw_irq_out            = raw_irq;
        masked_irq_out         = raw_irq && timeout_irq_enable;
        timeout_irq_signal_out = raw_irq && timeout_irq_enable;
        system_reset_out       = sys_reset;
    end
endmodule

//--- wdt_defs.svh
// Constants for the two-stage watchdog timer
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH
`define WDT_LOAD_RESET   32'hFFFFFFFF
`define WDT_UNLOCK_KEY   32'h1ACCE551
`define WDT_CTL_RESET_OUTPUT_ENABLE    1
`define WDT_CTL_TIMEOUT_IRQ_ENABLE    0
`define WDT_CTL_RESET    2'h0
`endif

//--- wdt_pkg.sv
// Types shared by the watchdog modules
package wdt_pkg;
    typedef logic [31:0] wdt_word_t;
    typedef enum logic [1:0] {
        WDT_IDLE,
        WDT_RUN,
        WDT_FIRED
    } wdt_state_e;
endpackage

//--- wdt_cnt_if.sv
// Counter control bundle between the watchdog control and its down counter
`timescale 1ns/1ns
interface wdt_cnt_if;
    import wdt_pkg::*;
    logic      load;
    wdt_word_t load_value;
    logic      run;
    logic      zero;
    wdt_word_t value;
    modport ctrl (output load, output load_value, output run, input zero, input value);
    modport cnt  (input load, input load_value, input run, output zero, output value);
endinterface

//--- wdt_counter.sv
// 32-bit down counter of the watchdog
`timescale 1ns/1ns
`include "wdt_defs.svh"
module wdt_counter (
    input  wire logic clk_in,
    input  wire logic resetn_in,
    wdt_cnt_if.cnt    cnt
);
    import wdt_pkg::*;

    wdt_word_t count;

    // Load wins over counting; the counter parks at zero until reloaded
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            count <= `WDT_LOAD_RESET;
        end else if (cnt.load) begin
            count <= cnt.load_value;
        end else if (cnt.run && count != 32'h00000000) begin
            count <= count - 32'h00000001;
        end
    end

    assign cnt.value = count;
    // Zero ignores the load strobe, since the load strobe itself follows zero
    assign cnt.zero  = cnt.run && (count == 32'h00000000);
endmodule

//--- wdt_chk.sv
// Port-level assertions for the two-stage watchdog
`timescale 1ns/1ns
`include "wdt_defs.svh"
module wdt_chk import wdt_pkg::*; (
    input wire logic       clk_in,
    input wire logic       resetn_in,
    input wire logic       load_wr_in,
    input wire wdt_word_t  load_data_in,
    input wire logic       irq_clear_wr_in,
    input wire logic       guard_wr_in,
    input wire wdt_word_t  guard_data_in,
    input wire logic       stall_enable_in,
    input wire logic       debug_halt_in,
    input wire wdt_word_t  reload_value_out,
    input wire wdt_word_t  count_value_out,
    input wire logic [1:0] ctrl_out,
    input wire logic       raw_irq_out,
    input wire logic       masked_irq_out,
    input wire logic       guard_locked_out,
    input wire logic       timeout_irq_signal_out,
    input wire logic       system_reset_out
);
    // Everything here lives in the one clock domain
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    a_load_takes: assert property (load_wr_in && !guard_locked_out && !system_reset_out |=>
        count_value_out == $past(load_data_in) && reload_value_out == $past(load_data_in))
        else $error("load write did not reach counter");
    a_masked_and: assert property (masked_irq_out == (raw_irq_out && ctrl_out[0]) &&
        timeout_irq_signal_out == masked_irq_out) else $error("masked status wrong");
    a_timeout_irq_enable_sticky: assert property (ctrl_out[0] |=> ctrl_out[0]) else $error("enable dropped");
    a_clear_drops: assert property (irq_clear_wr_in && !load_wr_in && count_value_out != 32'h0
        |=> !raw_irq_out) else $error("clear left interrupt");
    a_irq_holds: assert property (raw_irq_out && !irq_clear_wr_in |=> raw_irq_out)
        else $error("interrupt lost without clear");
    // A first zero while nothing is pending must fire and reload
    a_first_timeout: assert property (ctrl_out[0] && count_value_out == 32'h0 && !raw_irq_out &&
        !load_wr_in && !irq_clear_wr_in && !system_reset_out &&
        !($past(stall_enable_in, 2) && $past(debug_halt_in, 2))
        |=> raw_irq_out && count_value_out == $past(reload_value_out)) else $error("no first time-out");
    a_reset_second: assert property (raw_irq_out && ctrl_out == 2'h3 && count_value_out == 32'h0 &&
        !irq_clear_wr_in && !load_wr_in && !($past(stall_enable_in, 2) && $past(debug_halt_in, 2))
        |=> system_reset_out) else $error("no reset on second zero");
    a_reset_sticky: assert property (system_reset_out |=> system_reset_out) else $error("reset fell");
    a_guard_key: assert property (guard_wr_in |=>
        guard_locked_out == ($past(guard_data_in) != `WDT_UNLOCK_KEY)) else $error("lock state wrong");
    a_locked_load: assert property (guard_locked_out && load_wr_in |=> $stable(reload_value_out))
        else $error("locked load taken");
endmodule
bind wdt_top wdt_chk u_chk (
    .clk_in                 (clk_in),
    .resetn_in              (resetn_in),
    .load_wr_in             (load_wr_in),
    .load_data_in           (load_data_in),
    .irq_clear_wr_in        (irq_clear_wr_in),
    .guard_wr_in            (guard_wr_in),
    .guard_data_in          (guard_data_in),
    .stall_enable_in        (stall_enable_in),
    .debug_halt_in          (debug_halt_in),
    .reload_value_out       (reload_value_out),
    .count_value_out        (count_value_out),
    .ctrl_out               (ctrl_out),
    .raw_irq_out            (raw_irq_out),
    .masked_irq_out         (masked_irq_out),
    .guard_locked_out       (guard_locked_out),
    .timeout_irq_signal_out (timeout_irq_signal_out),
    .system_reset_out       (system_reset_out)
);

//--- wdt_sys_model.sv
// Stand-in for the processor interrupt input, counting NMI rising edges
`timescale 1ns/1ns
module wdt_sys_model (
    input  wire logic       clk_in,
    input  wire logic       resetn_in,
    input  wire logic       irq_in,
    output logic      [7:0] nmi_count_out
);
    logic irq_d;
    // Counts interrupt rising edges, as a level-blind handler would miss repeats
    always_ff @(posedge clk_in) begin
        irq_d <= irq_in;
        nmi_count_out <= !resetn_in ? 8'h0 : nmi_count_out + 8'(irq_in && !irq_d);
    end
endmodule

//--- testbench.sv
// Self-checking testbench for the two-stage watchdog
`timescale 1ns/1ns
`include "wdt_defs.svh"
module testbench;
    import wdt_pkg::*;
    logic       clk_in = 1'b0, resetn_in = 1'b0, load_wr_in = 1'b0, ctrl_wr_in = 1'b0, guard_wr_in = 1'b0;
    logic       irq_clear_wr_in = 1'b0, stall_enable_in = 1'b0, debug_halt_in = 1'b0;
    logic [1:0] ctrl_data_in = 2'h0, ctrl_out;
    wdt_word_t  load_data_in = 32'h0, guard_data_in = 32'h0, reload_value_out, count_value_out, c;
    logic       raw_irq_out, masked_irq_out, guard_locked_out, timeout_irq_signal_out, system_reset_out;
    logic [7:0] nmi_count;
    int         n_fail = 0, n_tests = 0, cycles = 0;
    wdt_top DUT (
        .clk_in                 (clk_in),
        .resetn_in              (resetn_in),
        .load_wr_in             (load_wr_in),
        .load_data_in           (load_data_in),
        .ctrl_wr_in             (ctrl_wr_in),
        .ctrl_data_in           (ctrl_data_in),
        .irq_clear_wr_in        (irq_clear_wr_in),
        .guard_wr_in            (guard_wr_in),
        .guard_data_in          (guard_data_in),
        .stall_enable_in        (stall_enable_in),
        .debug_halt_in          (debug_halt_in),
        .reload_value_out       (reload_value_out),
        .count_value_out        (count_value_out),
        .ctrl_out               (ctrl_out),
        .raw_irq_out            (raw_irq_out),
        .masked_irq_out         (masked_irq_out),
        .guard_locked_out       (guard_locked_out),
        .timeout_irq_signal_out (timeout_irq_signal_out),
        .system_reset_out       (system_reset_out)
    );
    wdt_sys_model u_sys (.clk_in(clk_in), .resetn_in(resetn_in), .irq_in(timeout_irq_signal_out),
        .nmi_count_out(nmi_count));
    // Clock runs from time zero, so every access finds the block clocked
    always #5 clk_in = ~clk_in;
    // One-cycle write pulse; k picks load, control, clear or guard
    task automatic wr(input int k, input wdt_word_t d);
        @(posedge clk_in);
        {load_wr_in, ctrl_wr_in, irq_clear_wr_in, guard_wr_in} <= {k == 0, k == 1, k == 2, k == 3};
        {load_data_in, guard_data_in, ctrl_data_in} <= {d, d, d[1:0]};
        @(posedge clk_in);
        {load_wr_in, ctrl_wr_in, irq_clear_wr_in, guard_wr_in} <= 4'h0;
        #1;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // Halt lines pass a two-stage synchroniser, so allow settling time
    task automatic hold(input logic h);
        @(posedge clk_in);
        {stall_enable_in, debug_halt_in} <= {h, h};
        idle(4);
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Hang guard, far above the roughly 85 cycles the sequence needs
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 1000) begin
            n_fail++;
            close_out;
        end
    end
    initial begin
        repeat (4) @(posedge clk_in);
        resetn_in <= 1'b1;
        #1 chk({ctrl_out, raw_irq_out, guard_locked_out, system_reset_out, count_value_out}, `WDT_LOAD_RESET);
        wr(0, 32'h0);
        chk({raw_irq_out, masked_irq_out}, 64'h2);
        wr(2, 32'h0);
        chk(raw_irq_out, 64'h0);
        wr(3, 32'h5);
        wr(0, 32'h9);
        chk({guard_locked_out, reload_value_out}, {1'b1, 32'h0});
        wr(3, `WDT_UNLOCK_KEY);
        wr(0, 32'h14);
        chk({guard_locked_out, reload_value_out}, {1'b0, 32'h14});
        wr(1, 32'h2);
        wr(1, 32'h3);
        chk({ctrl_out, count_value_out}, {2'h3, 32'h14});
        idle(5);
        chk(count_value_out, 64'hF);
        hold(1'b1);
        c = count_value_out;
        idle(3);
        chk(count_value_out, c);
        hold(1'b0);
        chk(count_value_out < c, 64'h1);
        wr(1, 32'h0);
        chk(ctrl_out, 64'h3);
        wr(0, 32'hA);
        chk(count_value_out, 64'hA);
        idle(11);
        chk({raw_irq_out, count_value_out}, {1'b1, 32'hA});
        chk(masked_irq_out, 64'h1);
        wr(0, 32'hA);
        chk({raw_irq_out, nmi_count}, {1'b1, 8'h1});
        wr(2, 32'h0);
        chk({raw_irq_out, count_value_out}, {1'b0, 32'hA});
        idle(11);
        chk({raw_irq_out, system_reset_out}, 64'h2);
        idle(11);
        chk(system_reset_out, 64'h1);
        @(posedge clk_in);
        resetn_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        resetn_in <= 1'b1;
        #1 chk({ctrl_out, system_reset_out}, 64'h0);
        close_out;
    end
endmodule
